// ==== verilog/aea_map.svh ====
`ifndef AEA_MAP_SVH
`define AEA_MAP_SVH
// ==========================================
// Register indices on the serial port
`define AEA_A_GAIN     5'h00
`define AEA_B_GAIN     5'h01
`define AEA_C_GAIN     5'h02
`define AEA_NOMV       5'h03
`define AEA_THR1       5'h04
`define AEA_THR0       5'h05
`define AEA_A_EN       5'h06
`define AEA_B_EN       5'h07
`define AEA_C_EN       5'h08
`define AEA_A_SMP      5'h09
`define AEA_B_SMP      5'h0a
`define AEA_C_SMP      5'h0b
`define AEA_STATUS     5'h0c
`define AEA_MASK       5'h0d
`define AEA_CALCMODE   5'h0e
`define AEA_LC_MODE    5'h0f
`define AEA_ACC_MODE   5'h10
`define AEA_LINECYC    5'h11
// ==========================================
// Field positions
`define AEA_HF_BIT      4
`define AEA_NOM_LSB     11
`define AEA_RDCLR_BIT   6
`define AEA_LCEN_BIT    2
`define AEA_ZXSEL_LSB   3
`define AEA_WIRE_LSB    4
// ==========================================
// Reset values
`define AEA_RST_GAIN    24'h000000
`define AEA_RST_NOMV    24'h000000
`define AEA_RST_THR     48'h000001ff6a6b
`define AEA_RST_LINECYC 16'hffff
// ==========================================
// Scaling, rms full scale is 2^23
`define AEA_FS_PWR      26'h1ff6a6b
`define AEA_NOMV_K      22'h2004b0
// ==========================================
// Timing
`define AEA_CLK_NS      100
`define AEA_SAMPLE_NS   125000
`define AEA_SAMPLE_CYC  ((`AEA_SAMPLE_NS) / (`AEA_CLK_NS))
`endif

// ==== verilog/aea_pkg.sv ====
package aea_pkg;
    // Internal processing width
    typedef logic signed [27:0] aea_proc_t;
    // Wiring field codes, in field order
    typedef enum logic [1:0] {
        AEA_WIRE_ALL,
        AEA_WIRE_NO_B,
        AEA_WIRE_B_NEG_AC,
        AEA_WIRE_B_NEG_A
    } aea_wiring_e;
endpackage

// ==== verilog/aea_phase_if.sv ====
`timescale 1ns/1ps
interface aea_phase_if;
    logic        tick;
    logic        kill;
    logic        nom_sel;
    logic        lc_mode;
    logic        lc_end;
    logic        clr;
    logic [23:0] vrms;
    logic [23:0] irms;
    logic [23:0] nomv;
    logic [23:0] gain;
    logic [47:0] thr;
    logic [23:0] sample;
    logic [31:0] energy;
    logic        hf_evt;
    logic        pulse;
    modport top (output tick, kill, nom_sel, lc_mode, lc_end, clr, vrms, irms,
                 nomv, gain, thr, input sample, energy, hf_evt, pulse);
    modport phase (input tick, kill, nom_sel, lc_mode, lc_end, clr, vrms, irms,
                   nomv, gain, thr, output sample, energy, hf_evt, pulse);
endinterface

// ==== verilog/aea_linecyc.sv ====
`timescale 1ns/1ps
`include "aea_map.svh"
module aea_linecyc
    import aea_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             clk_sys_in,
    input  wire logic             nrst_in,
    // Zero crossings
    input  wire logic [2:0]       zx_in,
    input  wire logic [2:0]       zx_sel_in,
    input  wire logic             enable_in,
    input  wire logic [CNT_W-1:0] linecyc_in,
    // Period end
    output logic                  end_out
);
    if (CNT_W < 1 || CNT_W > 16) begin : g_bad
        $error("CNT_W out of range");
    end
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } aea_lc_s;
    aea_lc_s     s;
    aea_lc_s     next_s;
    logic [1:0]  hits;
    logic [CNT_W:0] total;
    always_comb begin
        hits = 2'(zx_in[0] & zx_sel_in[0]) + 2'(zx_in[1] & zx_sel_in[1])
             + 2'(zx_in[2] & zx_sel_in[2]);
        total = {1'b0, s.cnt} + (CNT_W+1)'(hits);
        next_s.done = 1'b0;
        next_s.cnt  = s.cnt;
        if (!enable_in) begin
            next_s.cnt = '0;
        end else if (hits != 2'h0 && total >= {1'b0, linecyc_in}) begin
            next_s.cnt  = '0;
            next_s.done = 1'b1;
        end else begin
            next_s.cnt = total[CNT_W-1:0];
        end
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign end_out = s.done;
endmodule // aea_linecyc

// ==== verilog/aea_phase.sv ====
`timescale 1ns/1ps
`include "aea_map.svh"
module aea_phase
    import aea_pkg::*;
#(
    parameter int ACC_W = 48
) (
    // Clock and reset
    input  wire logic  clk_sys_in,
    input  wire logic  nrst_in,
    // Datapath link
    aea_phase_if.phase bus
);
    if (ACC_W < 48) begin : g_bad
        $error("ACC_W below threshold width");
    end
    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [31:0]      count;
        logic [31:0]      held;
        logic [23:0]      sample;
        logic             b30;
    } aea_phase_s;
    aea_phase_s        s;
    aea_phase_s        next_s;
    logic [45:0]       nomv_x;
    logic [23:0]       volt;
    logic [47:0]       vi;
    logic [50:0]       pw_x;
    aea_proc_t         power;
    aea_proc_t         gext;
    aea_proc_t         pg;
    logic signed [55:0] gp;
    logic [ACC_W-1:0]  sum;
    logic              pulse;
    logic [31:0]       cnt_inc;
    // ==========================================
    // Power, gain and threshold stage
    always_comb begin
        // Negative nominal voltage is meaningless, clamp it
        nomv_x = bus.nomv[23] ? 46'h0 : 46'(bus.nomv[22:0]) * 46'(`AEA_NOMV_K); // [R7]
        volt = bus.nom_sel ? nomv_x[43:20] : bus.vrms; // [R6] [R7]
        vi = 48'(volt) * 48'(bus.irms);
        pw_x = 51'(vi[47:23]) * 51'(`AEA_FS_PWR); // [R1] [R5]
        power = bus.kill ? 28'sh0 : aea_proc_t'(pw_x[50:23]); // [R17]
        gext = {{4{bus.gain[23]}}, bus.gain}; // [R4]
        gp = power * gext;
        pg = power + gp[50:23]; // [R2] [R3] [R18]
        sum = s.acc + ACC_W'(pg[27] ? 27'h0 : pg[26:0]); // [R9]
        pulse = bus.tick && (sum >= ACC_W'(bus.thr)); // [R9]
        cnt_inc = s.count + 32'(pulse); // [R12]
        next_s = s;
        if (bus.tick) begin
            next_s.sample = pg[27:4]; // [R1] [R18]
            next_s.acc = pulse ? sum - ACC_W'(bus.thr) : sum; // [R9]
        end
        if (bus.lc_mode) begin
            next_s.count = bus.lc_end ? 32'h0 : cnt_inc; // [R19]
            if (bus.lc_end) begin
                next_s.held = cnt_inc; // [R19]
            end
        end else begin
            // A pulse landing on the clearing read is kept
            next_s.count = bus.clr ? 32'(pulse) : cnt_inc; // [R16]
            next_s.held = next_s.count; // [R10]
        end
        next_s.b30 = s.held[30];
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign bus.sample = s.sample;
    assign bus.energy = s.held;
    assign bus.hf_evt = s.held[30] ^ s.b30; // [R13]
    assign bus.pulse  = pulse;
    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    chk_count_wrap: assert property ( // [R12]
        pulse && !bus.lc_mode && !bus.clr && s.count == 32'h7fffffff
        |=> s.count == 32'h80000000) else $error("energy count did not wrap");
    chk_gain_half: assert property ( // [R3]
        bus.gain == 24'hc00000 |-> (pg - (power >>> 1)) inside {28'sh0, 28'sh1})
        else $error("half gain wrong");
    chk_gain_unity: assert property ( // [R2]
        bus.gain == 24'h000000 |-> pg == power) else $error("zero gain alters power");
    chk_arith_path: assert property ( // [R6]
        !bus.nom_sel |-> volt == bus.vrms) else $error("rms voltage not used");
    chk_kill_zero: assert property ( // [R17]
        bus.kill && bus.tick |=> s.sample == 24'h0) else $error("phase not forced to zero");
    chk_lc_hold: assert property ( // [R19]
        bus.lc_mode && !bus.lc_end |=> $stable(s.held)) else $error("energy moved mid period");
    chk_acc_residue: assert property ( // [R9]
        bus.tick && !pulse |=> s.acc < $past(bus.thr)) else $error("accumulator over threshold");
    chk_sample_scale: assert property ( // [R1]
        bus.tick && !bus.kill && !bus.nom_sel && bus.gain == 24'h0
        && bus.vrms == 24'h400000 && bus.irms == 24'h400000
        |=> s.sample == 24'h07fda9) else $error("sample scaling wrong");
endmodule // aea_phase

// ==== verilog/aea_top.sv ====
// Functional notes
// R1 - Sample register holds V/Vfs times I/Ifs times full-scale power, over 16.
// R2 - Per-phase signed 24-bit gain multiplies power by one plus gain/2^23.
// R3 - Gain c00000 halves the power, 400000 raises it by half.
// R4 - Gain words read with four zero top bits, sign-extended to 28 bits.
// R5 - No offset correction in the apparent power path itself.
// R6 - Compute-mode bits 13:11 pick nominal voltage per phase, default clear.
// R7 - Nominal mode multiplies current rms by nominal value, full scale 4191905.
// R8 - Nominal voltage word carries eight zero top bits.
// R9 - Each 8 kHz sample adds power; at threshold, pulse and subtract.
// R10 - Pulses counted in 32-bit counters, shown in energy registers on access.
// R11 - 48-bit threshold reached as upper and lower 24-bit words.
// R12 - Energy registers are signed 32-bit and wrap to 80000000 upward.
// R13 - Status bit 4 sets when bit 30 of any energy register changes.
// R14 - Status bit 4 with mask bit 4 drives the interrupt low.
// R15 - Writing one to status bit 4 clears it and releases the interrupt.
// R16 - Line-cycle-mode bit 6 makes each energy read clear the register.
// R17 - Wiring field 5:4 zeroes phase B or derives its voltage.
// R18 - Gain follows the arithmetic or nominal choice, feeding sample and energy.
// R19 - Line-cycle bit 2 updates energy at period end, without clearing reads.
`timescale 1ns/1ps
`include "aea_map.svh"
module aea_top
    import aea_pkg::*;
#(
    parameter int ACC_W     = 48,
    parameter int LINECYC_W = 16
) (
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              nrst_in,
    // Register port
    input  wire logic [4:0]        reg_addr_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic [31:0]       reg_wdata_in,
    output logic      [31:0]       reg_rdata_out,
    // Rms values, index 0 is phase A
    input  wire logic [2:0][23:0]  vrms_in,
    input  wire logic [2:0][23:0]  irms_in,
    input  wire logic [23:0]       vrms_ac_sum_in,
    // Zero crossing pulses
    input  wire logic [2:0]        zx_in,
    // Interrupt
    output logic                   primary_interrupt_n_out
);
    if (LINECYC_W != 16) begin : g_bad
        $error("LINECYC_W must be 16");
    end
    localparam int unsigned SAMPLE_CYC = `AEA_SAMPLE_CYC;
    if (SAMPLE_CYC < 2 || SAMPLE_CYC > 2048) begin : g_bad_cyc
        $error("sample period does not fit tick counter");
    end
    // ==========================================
    // State
    typedef struct packed {
        logic [2:0][23:0]      gain;
        logic [23:0]           nomv;
        logic [47:0]           thr;
        logic                  hf;
        logic                  mask;
        logic [2:0]            nom_sel;
        logic [6:0]            lcyc;
        logic [1:0]            wire_sel;
        logic [LINECYC_W-1:0]  linecyc;
        logic [10:0]           tick_cnt;
        logic [31:0]           rdata;
        logic                  irq_n;
    } aea_top_s;
    localparam aea_top_s RST = '{
        gain:    {3{`AEA_RST_GAIN}},
        nomv:    `AEA_RST_NOMV,
        thr:     `AEA_RST_THR,
        linecyc: `AEA_RST_LINECYC,
        irq_n:   1'b1,
        default: '0
    };
    aea_top_s          s;
    aea_top_s          next_s;
    logic              tick;
    logic              lc_mode;
    logic              rd_rst;
    logic              hf_clr;
    logic              lc_end;
    aea_wiring_e       wiring;
    logic [2:0][23:0]  vsel;
    logic [2:0][31:0]  energy;
    logic [2:0][23:0]  sample;
    logic [2:0]        hf_evt;
    logic [2:0]        pulse;
    aea_phase_if       pif [3] ();
    // ==========================================
    // Sample strobe and mode decode
    assign tick    = s.tick_cnt == 11'(SAMPLE_CYC - 1); // [R9]
    assign lc_mode = s.lcyc[`AEA_LCEN_BIT];
    // Clearing reads would corrupt a line-cycle period, so they are blocked
    assign rd_rst  = reg_rd_in && s.lcyc[`AEA_RDCLR_BIT] && !lc_mode; // [R16] [R19]
    assign hf_clr  = reg_wr_in && reg_addr_in == `AEA_STATUS
                     && reg_wdata_in[`AEA_HF_BIT]; // [R15]
    assign wiring  = aea_wiring_e'(s.wire_sel);
    always_comb begin
        vsel = vrms_in;
        unique case (wiring) // [R17]
            AEA_WIRE_ALL:      ;
            AEA_WIRE_NO_B:     ;
            AEA_WIRE_B_NEG_AC: vsel[1] = vrms_ac_sum_in;
            AEA_WIRE_B_NEG_A:  vsel[1] = vrms_in[0];
        endcase
    end
    // ==========================================
    // Phase datapaths
    for (genvar g = 0; g < 3; g++) begin : g_ph
        aea_phase #(
            .ACC_W      (ACC_W)
        ) u_phase (
            .clk_sys_in (clk_sys_in),
            .nrst_in    (nrst_in),
            .bus        (pif[g])
        );
        assign pif[g].tick    = tick;
        assign pif[g].kill    = (g == 1) && wiring == AEA_WIRE_NO_B; // [R17]
        assign pif[g].nom_sel = s.nom_sel[g]; // [R6]
        assign pif[g].lc_mode = lc_mode;
        assign pif[g].lc_end  = lc_end;
        assign pif[g].clr     = rd_rst && reg_addr_in == 5'(`AEA_A_EN + g); // [R16]
        assign pif[g].vrms    = vsel[g];
        assign pif[g].irms    = irms_in[g];
        assign pif[g].nomv    = s.nomv;
        assign pif[g].gain    = s.gain[g];
        assign pif[g].thr     = s.thr;
        assign energy[g]      = pif[g].energy;
        assign sample[g]      = pif[g].sample;
        assign hf_evt[g]      = pif[g].hf_evt;
        assign pulse[g]       = pif[g].pulse;
    end
    aea_linecyc #(
        .CNT_W      (LINECYC_W)
    ) u_linecyc (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .zx_in      (zx_in),
        .zx_sel_in  (s.lcyc[`AEA_ZXSEL_LSB +: 3]),
        .enable_in  (lc_mode),
        .linecyc_in (s.linecyc),
        .end_out    (lc_end)
    );
    // ==========================================
    // Register writes, status and read data
    always_comb begin
        next_s = s;
        next_s.tick_cnt = tick ? 11'h0 : s.tick_cnt + 11'h1;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `AEA_A_GAIN:   next_s.gain[0] = reg_wdata_in[23:0]; // [R4]
                `AEA_B_GAIN:   next_s.gain[1] = reg_wdata_in[23:0];
                `AEA_C_GAIN:   next_s.gain[2] = reg_wdata_in[23:0];
                `AEA_NOMV:     next_s.nomv = reg_wdata_in[23:0]; // [R8]
                `AEA_THR1:     next_s.thr[47:24] = reg_wdata_in[23:0]; // [R11]
                `AEA_THR0:     next_s.thr[23:0] = reg_wdata_in[23:0]; // [R11]
                `AEA_MASK:     next_s.mask = reg_wdata_in[`AEA_HF_BIT];
                `AEA_CALCMODE: next_s.nom_sel = reg_wdata_in[`AEA_NOM_LSB +: 3]; // [R6]
                `AEA_LC_MODE:  next_s.lcyc = reg_wdata_in[6:0];
                `AEA_ACC_MODE: next_s.wire_sel = reg_wdata_in[`AEA_WIRE_LSB +: 2];
                `AEA_LINECYC:  next_s.linecyc = reg_wdata_in[LINECYC_W-1:0];
                default:       ;
            endcase
        end
        // A new half-full event beats a clear in the same cycle
        next_s.hf = (|hf_evt) || (s.hf && !hf_clr); // [R13] [R15]
        next_s.irq_n = !(next_s.hf && next_s.mask); // [R14] [R15]
        if (reg_rd_in) begin
            case (reg_addr_in)
                `AEA_A_GAIN:   next_s.rdata = {4'h0, {4{s.gain[0][23]}}, s.gain[0]}; // [R4]
                `AEA_B_GAIN:   next_s.rdata = {4'h0, {4{s.gain[1][23]}}, s.gain[1]};
                `AEA_C_GAIN:   next_s.rdata = {4'h0, {4{s.gain[2][23]}}, s.gain[2]};
                `AEA_NOMV:     next_s.rdata = {8'h0, s.nomv}; // [R8]
                `AEA_THR1:     next_s.rdata = {8'h0, s.thr[47:24]}; // [R11]
                `AEA_THR0:     next_s.rdata = {8'h0, s.thr[23:0]};
                `AEA_A_EN:     next_s.rdata = energy[0]; // [R10]
                `AEA_B_EN:     next_s.rdata = energy[1];
                `AEA_C_EN:     next_s.rdata = energy[2];
                `AEA_A_SMP:    next_s.rdata = {{8{sample[0][23]}}, sample[0]};
                `AEA_B_SMP:    next_s.rdata = {{8{sample[1][23]}}, sample[1]};
                `AEA_C_SMP:    next_s.rdata = {{8{sample[2][23]}}, sample[2]};
                `AEA_STATUS:   next_s.rdata = 32'(s.hf) << `AEA_HF_BIT;
                `AEA_MASK:     next_s.rdata = 32'(s.mask) << `AEA_HF_BIT;
                `AEA_CALCMODE: next_s.rdata = 32'(s.nom_sel) << `AEA_NOM_LSB;
                `AEA_LC_MODE:  next_s.rdata = {25'h0, s.lcyc};
                `AEA_ACC_MODE: next_s.rdata = 32'(s.wire_sel) << `AEA_WIRE_LSB;
                `AEA_LINECYC:  next_s.rdata = 32'(s.linecyc);
                default:       next_s.rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end
    assign reg_rdata_out           = s.rdata;
    assign primary_interrupt_n_out = s.irq_n;
    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    chk_irq_follows_hf: assert property ( // [R14]
        s.hf && s.mask |-> !primary_interrupt_n_out) else $error("interrupt not low");
    chk_irq_idle: assert property ( // [R15]
        !s.hf |-> primary_interrupt_n_out) else $error("interrupt low without status");
    chk_hf_sets: assert property ( // [R13]
        |hf_evt |=> s.hf) else $error("half-full not set");
    chk_hf_clears: assert property ( // [R15]
        hf_clr && !(|hf_evt) |=> !s.hf && primary_interrupt_n_out)
        else $error("half-full not cleared");
    chk_read_clears: assert property ( // [R16]
        rd_rst && reg_addr_in == `AEA_A_EN |=> energy[0] <= 32'h1)
        else $error("read did not clear energy");
    chk_energy_read: assert property ( // [R10]
        reg_rd_in && reg_addr_in == `AEA_B_EN |=> reg_rdata_out == $past(energy[1]))
        else $error("energy read wrong");
    chk_tick_spacing: assert property ( // [R9]
        tick |=> !tick [*8]) else $error("sample strobe too close");
    chk_lc_no_clear: assert property ( // [R19]
        lc_mode |-> !rd_rst) else $error("clearing read in line-cycle mode");
    cov_hf_irq:    cover property (s.hf && s.mask && !primary_interrupt_n_out);
    cov_read_rst:  cover property (rd_rst && reg_addr_in == `AEA_C_EN);
    cov_lc_end:    cover property (lc_end);
    cov_pulse_all: cover property (&pulse);
endmodule // aea_top

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "aea_map.svh"
module tb_top
    import aea_pkg::*;
;
    // ==========================================
    // Signals
    localparam logic [31:0] PWR = 32'h007fda9a;
    logic                  clk_sys_in              = 1'b0;
    logic                  nrst_in                 = 1'b0;
    logic [4:0]            reg_addr_in             = 5'h00;
    logic                  reg_wr_in               = 1'b0;
    logic                  reg_rd_in               = 1'b0;
    logic [31:0]           reg_wdata_in            = 32'h0;
    logic [31:0]           reg_rdata_out;
    logic [2:0][23:0]      vrms_in                 = '0;
    logic [2:0][23:0]      irms_in                 = '0;
    logic [23:0]           vrms_ac_sum_in          = 24'h0;
    logic [2:0]            zx_in                   = 3'h0;
    logic                  primary_interrupt_n_out;
    int                    n_fail                  = 0;
    int                    n_checks                = 0;
    logic [31:0]           v;
    logic [31:0]           prev;

    always #50 clk_sys_in = ~clk_sys_in;

    aea_top uut (
        .clk_sys_in              (clk_sys_in),
        .nrst_in                 (nrst_in),
        .reg_addr_in             (reg_addr_in),
        .reg_wr_in               (reg_wr_in),
        .reg_rd_in               (reg_rd_in),
        .reg_wdata_in            (reg_wdata_in),
        .reg_rdata_out           (reg_rdata_out),
        .vrms_in                 (vrms_in),
        .irms_in                 (irms_in),
        .vrms_ac_sum_in          (vrms_ac_sum_in),
        .zx_in                   (zx_in),
        .primary_interrupt_n_out (primary_interrupt_n_out)
    );

    // ==========================================
    // Bus cycles and compare
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(negedge clk_sys_in);
        reg_addr_in  = a;
        reg_wdata_in = d;
        reg_wr_in    = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_in    = 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(negedge clk_sys_in);
        reg_addr_in = a;
        reg_rd_in   = 1'b1;
        @(negedge clk_sys_in);
        reg_rd_in   = 1'b0;
        d           = reg_rdata_out;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(name, exp, d);
    endtask

    // Samples refresh only on the 8 kHz strobe, so allow one full period
    task automatic settle();
        repeat (1300) @(negedge clk_sys_in);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd_chk("gain a reset", `AEA_A_GAIN, 32'h0);
        rd_chk("nominal reset", `AEA_NOMV, 32'h0);
        rd_chk("thr upper reset", `AEA_THR1, 32'h00000001);
        rd_chk("thr lower reset", `AEA_THR0, 32'h00ff6a6b);
        rd_chk("line count reset", `AEA_LINECYC, 32'h0000ffff);
        rd_chk("unmapped", 5'h1f, 32'h0);
        wr(`AEA_A_GAIN, 32'h00c00000);
        rd_chk("gain a rw", `AEA_A_GAIN, 32'h0fc00000);
        wr(`AEA_A_GAIN, 32'h0);
        wr(`AEA_A_EN, 32'h12345678);
        rd_chk("energy ro", `AEA_A_EN, 32'h0);
        wr(`AEA_MASK, 32'h00000010);
        rd_chk("mask rw", `AEA_MASK, 32'h00000010);
        wr(`AEA_STATUS, 32'h00000010);
        chk("irq idle", 32'h1, {31'h0, primary_interrupt_n_out});
    endtask

    task automatic t_gain();
        vrms_in = {3{24'h400000}};
        irms_in = {3{24'h400000}};
        wr(`AEA_B_GAIN, 32'h00c00000);
        wr(`AEA_C_GAIN, 32'h00400000);
        settle();
        rd_chk("sample a", `AEA_A_SMP, 32'h0007fda9);
        rd_chk("sample b half", `AEA_B_SMP, 32'h0003fed4);
        rd_chk("sample c more", `AEA_C_SMP, 32'h000bfc7e);
        wr(`AEA_B_GAIN, 32'h0);
    endtask

    task automatic t_wiring();
        logic [31:0] exp_b [4];
        aea_wiring_e w;
        exp_b          = '{32'h0, 32'h0, 32'h0007fda9, 32'h0007fda9};
        vrms_in[1]     = 24'h0;
        vrms_ac_sum_in = 24'h400000;
        for (int m = 0; m < 4; m++) begin
            w = aea_wiring_e'(m);
            wr(`AEA_ACC_MODE, {26'h0, w, 4'h0});
            settle();
            rd_chk("sample b wiring", `AEA_B_SMP, exp_b[m]);
        end
        wr(`AEA_ACC_MODE, 32'h0);
    endtask

    task automatic t_nominal();
        vrms_in[0] = 24'h100000;
        wr(`AEA_NOMV, 32'h00200000);
        rd_chk("nominal rw", `AEA_NOMV, 32'h00200000);
        wr(`AEA_CALCMODE, 32'h00000800);
        settle();
        rd_chk("sample a nominal", `AEA_A_SMP, 32'h0007fed5);
        wr(`AEA_CALCMODE, 32'h0);
        vrms_in[0] = 24'h400000;
        settle();
        rd_chk("sample a arith", `AEA_A_SMP, 32'h0007fda9);
    endtask

    // Reads are exactly one or two strobe periods apart, so one pulse each
    task automatic t_energy();
        wr(`AEA_THR1, 32'h0);
        wr(`AEA_THR0, PWR);
        wr(`AEA_LC_MODE, 32'h00000040);
        settle();
        rd(`AEA_A_EN, v);
        for (int k = 0; k < 2; k++) begin
            repeat (1248) @(negedge clk_sys_in);
            rd_chk("energy one period", `AEA_A_EN, 32'h1);
        end
        wr(`AEA_THR0, PWR << 1);
        // Old residue may span several steps; let it drain below one
        repeat (4) settle();
        rd(`AEA_A_EN, v);
        for (int k = 0; k < 2; k++) begin
            repeat (2498) @(negedge clk_sys_in);
            rd_chk("energy two periods", `AEA_A_EN, 32'h1);
        end
    endtask

    task automatic t_line_cycle();
        wr(`AEA_LINECYC, 32'h2);
        wr(`AEA_LC_MODE, 32'h0000004c);
        rd(`AEA_A_EN, prev);
        repeat (2600) @(negedge clk_sys_in);
        rd_chk("energy frozen", `AEA_A_EN, prev);
        for (int k = 0; k < 2; k++) begin
            @(negedge clk_sys_in);
            zx_in = 3'h1;
            @(negedge clk_sys_in);
            zx_in = 3'h0;
        end
        repeat (3) @(negedge clk_sys_in);
        rd(`AEA_A_EN, v);
        chk("energy period end", 32'h1, {31'h0, v !== prev});
    endtask

    // ==========================================
    // Sequence and verdict
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        t_reset();
        t_gain();
        t_wiring();
        t_nominal();
        t_energy();
        t_line_cycle();
        conclude();
    end

    // Whole run needs about 26000 cycles
    initial begin
        repeat (50000) @(posedge clk_sys_in);
        n_fail++;
        conclude();
    end
endmodule // tb_top
